/* rtl/hsu_cfg.svh */
`ifndef HSU_CFG_SVH
`define HSU_CFG_SVH
// Register addresses on the special function register port
`define HSU_ADDR_FLAGS 8'h9F
`define HSU_ADDR_IRQEN 8'hA1
`define HSU_ADDR_DATA 8'hA2
`define HSU_ADDR_DEPTH 8'hA3
`define HSU_ADDR_STA 8'hAB
`define HSU_ADDR_CTR 8'hAC
`define HSU_ADDR_PRE 8'hAD
`define HSU_ADDR_CNT 8'hAE
// Field positions
`define HSU_FLAG_CLEAR 7
`define SERIAL_STATUS_SET 7
`define SERIAL_STATUS_NOPRE 4
`define SERIAL_STATUS_OVR_EN 3
`define SERIAL_STATUS_FER_EN 2
`define SERIAL_STATUS_OVR 1
`define SERIAL_STATUS_FER 0
`define SERIAL_CONTROL_WAKE 7
`define SERIAL_CONTROL_START 6
`define SERIAL_CONTROL_TXSTOP_HI 5
`define SERIAL_CONTROL_TXSTOP_LO 4
`define SERIAL_CONTROL_RXSTOP 3
`define SERIAL_CONTROL_TXEN 2
`define SERIAL_CONTROL_RXEN 1
`define SERIAL_CONTROL_SRST 0
// Reset values and limits
`define SERIAL_CONTROL_RESET 8'h01
`define HSU_RX_DEPTH_MAX 8'hB6
`define HSU_PRE_MAX 8'h08
`define HSU_WAKE_COUNT 3'h5
`define HSU_PREAMBLE_ZERO 8'h00
`define HSU_PREAMBLE_LAST 8'hFF
`endif

/* rtl/hsu_pkg.sv */
`default_nettype none
package hsu_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hsu_rx_st_t;
  typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_STOP} hsu_tx_st_t;
endpackage : hsu_pkg
`default_nettype wire

/* rtl/hsu_ram.sv */
`default_nettype none
module hsu_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port, data one cycle later
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd_data;
  } hsu_ram_state_t;

  hsu_ram_state_t st;
  hsu_ram_state_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      next_st.rd_data = st.mem[rd_addr];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
endmodule : hsu_ram
`default_nettype wire

/* rtl/hsu_uart.sv */
// Summary of operation
// R01 - Level, overrun, full flags gated by enables
// R02 - Group enable also gates CPU interrupt
// R03 - Data port write pushes transmit FIFO
// R04 - Data port read pops oldest receive byte
// R05 - Receive depth register, reset zero, max 182
// R06 - Remaining RAM serves as transmit FIFO
// R07 - Bytes beyond receive depth are discarded
// R08 - Eight data bits, LSB first, full duplex
// R09 - Low receive line marks start bit
// R10 - Stop bits sampled high; one or two
// R11 - Transmitter appends one to four stop bits
// R12 - Prescaler divides by two to setting
// R13 - Prescaler and counter set bit timing
// R14 - Bit timing derived from block clock
// R15 - Armed filter withholds 00 00 FF preamble
// R16 - Firmware rearms filter between frames
// R17 - Unarmed filter passes every character
// R18 - Three-bit counter counts receive rising edges
// R19 - Count five raises wake request
// R20 - Firmware clears wake counter before power-down
// R21 - Holding buffer lets reception continue
// R22 - Gated flags ORed into one request
// R23 - Low stop sample flags framing error
// R24 - Stop bits sent equal field plus one
// R25 - Full FIFO drops byte, sets overrun
// R26 - Counter wraps at setting, one tick per bit
`include "hsu_cfg.svh"
`default_nettype none
module hsu_uart import hsu_pkg::*; #(
  parameter int RAM_DEPTH = 256,
  parameter int RX_WATERMARK = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // CPU interrupt
  input wire logic peripheral_group_irq_enable,
  output logic cpu_irq,
  // Serial link
  input wire logic serial_rx,
  output logic serial_tx,
  // Wake-up from soft power-down
  output logic wake_request
);
  localparam int AW = $clog2(RAM_DEPTH);
  typedef logic [AW-1:0] hsu_ptr_t;
  typedef logic [AW:0] baud_counter_t;

  typedef struct packed {
    hsu_rx_st_t rx_st;
    hsu_tx_st_t tx_st;
    logic [7:0] pre_cnt;
    logic [7:0] tx_baud;
    logic [7:0] rx_baud;
    logic [2:0] rx_bit;
    logic rx_stops;
    logic [7:0] rx_shift;
    logic hold_valid;
    logic [7:0] hold_data;
    logic armed;
    logic [1:0] pre_stage;
    hsu_ptr_t rx_head;
    hsu_ptr_t rx_tail;
    baud_counter_t rx_count;
    hsu_ptr_t tx_head;
    hsu_ptr_t tx_tail;
    baud_counter_t tx_count;
    logic [7:0] tx_shift;
    logic [2:0] tx_bit;
    logic [1:0] tx_stops;
    logic tx_line;
    logic [2:0] flags;
    logic [7:0] irq_en;
    logic [7:0] depth;
    logic [4:0] sta;
    logic [7:0] ctr;
    logic [7:0] pre;
    logic [7:0] cnt;
    logic rx_prev;
    logic [2:0] wake_cnt;
    logic wake;
    logic irq;
    logic rd_pend;
    logic rd_ok;
    logic [7:0] rd_addr;
    logic [7:0] rdata;
  } hsu_state_t;

  localparam baud_counter_t WMARK = baud_counter_t'(RX_WATERMARK);

  hsu_state_t st;
  hsu_state_t next_st;
  logic ram_we;
  hsu_ptr_t ram_waddr;
  logic [7:0] ram_wdata;
  logic ram_re;
  hsu_ptr_t ram_raddr;
  logic [7:0] ram_rdata;
  logic soft_run;
  logic [7:0] pre_eff;
  logic [7:0] pmask;
  logic ptick;
  logic tx_tick;
  logic rx_sample;
  logic cpu_push;
  logic cpu_pop;
  logic tx_fetch;
  logic rx_store;
  logic rx_drop;
  logic byte_done;
  logic wake_edge;
  baud_counter_t tx_cap;
  logic [2:0] flag_set;
  logic [2:0] flag_wset;
  logic [2:0] flag_clr;
  logic [1:0] sta_set;

  function automatic hsu_ptr_t rx_inc(hsu_ptr_t p, logic [7:0] d);
    rx_inc = ({1'b0, p} + 1'b1 >= baud_counter_t'(d)) ? '0 : p + 1'b1;
  endfunction : rx_inc

  function automatic hsu_ptr_t tx_inc(hsu_ptr_t p, logic [7:0] d);
    tx_inc = ({1'b0, p} + 1'b1 >= baud_counter_t'(RAM_DEPTH)) ? hsu_ptr_t'(d) : p + 1'b1;
  endfunction : tx_inc

  hsu_ram #(
    .WIDTH(8),
    .DEPTH(RAM_DEPTH),
    .AW(AW)
  ) u_ram (
    .clock(clock),
    .rstn(rstn),
    .wr_en(ram_we),
    .wr_addr(ram_waddr),
    .wr_data(ram_wdata),
    .rd_en(ram_re),
    .rd_addr(ram_raddr),
    .rd_data(ram_rdata)
  );

  always_comb begin
    next_st = st;
    ram_we = 1'b0;
    ram_waddr = '0;
    ram_wdata = 8'h00;
    ram_re = 1'b0;
    ram_raddr = '0;
    flag_set = 3'h0;
    flag_wset = 3'h0;
    flag_clr = 3'h0;
    sta_set = 2'h0;
    byte_done = 1'b0;
    soft_run = st.ctr[`SERIAL_CONTROL_SRST];

    // Baud generator: prescaler then bit counter
    pre_eff = (st.pre > `HSU_PRE_MAX) ? `HSU_PRE_MAX : st.pre; // R12
    pmask = 8'((9'h001 << pre_eff[3:0]) - 9'h001); // R12
    ptick = st.pre_cnt == pmask; // R14
    next_st.pre_cnt = ptick ? 8'h00 : st.pre_cnt + 8'h01;
    tx_tick = ptick && st.tx_baud == st.cnt; // R26
    rx_sample = ptick && st.rx_baud == {1'b0, st.cnt[7:1]}; // R13
    if (ptick) begin
      next_st.tx_baud = tx_tick ? 8'h00 : st.tx_baud + 8'h01; // R26
      next_st.rx_baud = (st.rx_baud == st.cnt) ? 8'h00 : st.rx_baud + 8'h01; // R26
    end

    // FIFO requests from the CPU, the transmitter and the receive holding buffer
    tx_cap = baud_counter_t'(RAM_DEPTH) - baud_counter_t'(st.depth); // R06
    cpu_pop = sfr_rd && sfr_addr == `HSU_ADDR_DATA && st.rx_count != '0; // R04
    cpu_push = sfr_wr && sfr_addr == `HSU_ADDR_DATA && st.tx_count < tx_cap; // R03
    tx_fetch = st.tx_st == TX_IDLE && soft_run && st.ctr[`SERIAL_CONTROL_TXEN]
               && st.tx_count != '0 && !cpu_pop;
    rx_store = st.hold_valid && !cpu_push && st.rx_count < baud_counter_t'(st.depth); // R21
    rx_drop = st.hold_valid && !cpu_push && !rx_store; // R07

    if (cpu_pop) begin
      ram_re = 1'b1;
      ram_raddr = st.rx_head; // R04
      next_st.rx_head = rx_inc(st.rx_head, st.depth);
    end else if (tx_fetch) begin
      ram_re = 1'b1;
      ram_raddr = st.tx_head;
      next_st.tx_head = tx_inc(st.tx_head, st.depth);
    end
    if (cpu_push) begin
      ram_we = 1'b1;
      ram_waddr = st.tx_tail; // R03
      ram_wdata = sfr_wdata;
      next_st.tx_tail = tx_inc(st.tx_tail, st.depth); // R06
    end else if (rx_store) begin
      ram_we = 1'b1;
      ram_waddr = st.rx_tail;
      ram_wdata = st.hold_data;
      next_st.rx_tail = rx_inc(st.rx_tail, st.depth);
    end
    if (rx_store || rx_drop) begin
      next_st.hold_valid = 1'b0;
    end
    if (rx_drop) begin
      flag_set[1] = 1'b1; // R25
      sta_set[`SERIAL_STATUS_OVR] = 1'b1; // R25
    end
    case ({rx_store, cpu_pop})
      2'b10: next_st.rx_count = st.rx_count + 1'b1;
      2'b01: next_st.rx_count = st.rx_count - 1'b1;
      default: next_st.rx_count = st.rx_count;
    endcase
    case ({cpu_push, tx_fetch})
      2'b10: next_st.tx_count = st.tx_count + 1'b1;
      2'b01: next_st.tx_count = st.tx_count - 1'b1;
      default: next_st.tx_count = st.tx_count;
    endcase

    // Receiver
    case (st.rx_st)
      RX_IDLE: begin
        // Only a falling edge starts a frame, so a low stop bit is not taken as a start
        if (!serial_rx && st.rx_prev) begin // R09
          next_st.rx_baud = 8'h00;
          next_st.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (rx_sample) begin
          next_st.rx_bit = 3'h0;
          next_st.rx_st = serial_rx ? RX_IDLE : RX_DATA; // R09
        end
      end
      RX_DATA: begin
        if (rx_sample) begin
          next_st.rx_shift = {serial_rx, st.rx_shift[7:1]}; // R08
          next_st.rx_bit = st.rx_bit + 3'h1;
          if (st.rx_bit == 3'h7) begin
            next_st.rx_stops = st.ctr[`SERIAL_CONTROL_RXSTOP]; // R10
            next_st.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_sample) begin
          if (!serial_rx) begin
            sta_set[`SERIAL_STATUS_FER] = 1'b1; // R23
            next_st.rx_st = RX_IDLE;
          end else if (!st.rx_stops) begin
            byte_done = 1'b1; // R10
            next_st.rx_st = RX_IDLE;
          end else begin
            next_st.rx_stops = 1'b0;
          end
        end
      end
      default: next_st.rx_st = RX_IDLE;
    endcase
    if (!soft_run || !st.ctr[`SERIAL_CONTROL_RXEN]) begin
      next_st.rx_st = RX_IDLE;
      byte_done = 1'b0;
    end

    // Preamble filter in front of the holding buffer
    if (byte_done) begin
      if (st.sta[`SERIAL_STATUS_NOPRE] || !st.armed) begin
        next_st.hold_valid = 1'b1; // R17
        next_st.hold_data = st.rx_shift; // R21
      end else if (st.pre_stage == 2'h2) begin
        if (st.rx_shift == `HSU_PREAMBLE_LAST) begin
          next_st.armed = 1'b0; // R15
          next_st.pre_stage = 2'h0;
        end else if (st.rx_shift != `HSU_PREAMBLE_ZERO) begin
          next_st.pre_stage = 2'h0;
        end
      end else begin
        next_st.pre_stage = (st.rx_shift == `HSU_PREAMBLE_ZERO) ? st.pre_stage + 2'h1 : 2'h0;
      end
    end

    // Transmitter
    case (st.tx_st)
      TX_IDLE: begin
        if (tx_fetch) begin
          next_st.tx_st = TX_LOAD;
        end
      end
      TX_LOAD: begin
        next_st.tx_shift = ram_rdata;
        next_st.tx_st = TX_START;
      end
      TX_START: begin
        if (tx_tick) begin
          next_st.tx_line = 1'b0;
          next_st.tx_bit = 3'h0;
          next_st.tx_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          next_st.tx_line = st.tx_shift[0]; // R08
          next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
          next_st.tx_bit = st.tx_bit + 3'h1;
          if (st.tx_bit == 3'h7) begin
            next_st.tx_stops = st.ctr[`SERIAL_CONTROL_TXSTOP_HI:`SERIAL_CONTROL_TXSTOP_LO]; // R24
            next_st.tx_st = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          next_st.tx_line = 1'b1; // R11
          if (st.tx_stops == 2'h0) begin
            next_st.tx_st = TX_IDLE;
          end else begin
            next_st.tx_stops = st.tx_stops - 2'h1; // R11
          end
        end
      end
      default: next_st.tx_st = TX_IDLE;
    endcase
    if (!soft_run) begin
      next_st.tx_st = TX_IDLE;
      next_st.tx_line = 1'b1;
    end

    // Wake-up edge counter saturates at its target
    next_st.rx_prev = serial_rx;
    wake_edge = serial_rx && !st.rx_prev && st.wake_cnt != `HSU_WAKE_COUNT; // R18
    if (wake_edge) begin
      next_st.wake_cnt = st.wake_cnt + 3'h1; // R18
    end

    // Register writes
    if (sfr_wr) begin
      case (sfr_addr)
        `HSU_ADDR_FLAGS: begin
          if (sfr_wdata[`HSU_FLAG_CLEAR]) begin
            flag_clr = sfr_wdata[2:0];
          end else begin
            flag_wset = sfr_wdata[2:0];
          end
        end
        `HSU_ADDR_IRQEN: next_st.irq_en = sfr_wdata;
        `HSU_ADDR_DEPTH: begin
          next_st.depth = (sfr_wdata > `HSU_RX_DEPTH_MAX) ? `HSU_RX_DEPTH_MAX : sfr_wdata; // R05
          next_st.rx_head = '0;
          next_st.rx_tail = '0;
          next_st.rx_count = '0;
          next_st.tx_head = hsu_ptr_t'(next_st.depth); // R06
          next_st.tx_tail = hsu_ptr_t'(next_st.depth);
          next_st.tx_count = '0;
        end
        `HSU_ADDR_STA: begin
          if (sfr_wdata[`SERIAL_STATUS_SET]) begin
            next_st.sta = st.sta | sfr_wdata[4:0];
          end else begin
            next_st.sta = st.sta & ~sfr_wdata[4:0];
          end
        end
        `HSU_ADDR_CTR: begin
          next_st.ctr = {sfr_wdata[7], 1'b0, sfr_wdata[5:0]};
          if (sfr_wdata[`SERIAL_CONTROL_START]) begin
            next_st.armed = 1'b1; // R16
            next_st.pre_stage = 2'h0;
          end
          if (sfr_wdata[`SERIAL_CONTROL_WAKE]) begin
            next_st.wake_cnt = {2'h0, wake_edge}; // R20
          end
        end
        `HSU_ADDR_PRE: next_st.pre = sfr_wdata;
        `HSU_ADDR_CNT: next_st.cnt = sfr_wdata;
        default: ;
      endcase
    end
    next_st.wake = next_st.wake_cnt == `HSU_WAKE_COUNT; // R19

    // Sticky flags: a hardware set wins over a clear
    flag_set[2] = next_st.rx_count >= WMARK;
    flag_set[0] = next_st.rx_count == baud_counter_t'(next_st.depth);
    next_st.flags = (st.flags & ~flag_clr) | flag_wset | flag_set;
    next_st.sta[1:0] = next_st.sta[1:0] | sta_set;
    next_st.irq = peripheral_group_irq_enable // R02
                  && (|(st.flags & st.irq_en[2:0]) // R01
                  || (st.sta[`SERIAL_STATUS_OVR] && st.sta[`SERIAL_STATUS_OVR_EN])
                  || (st.sta[`SERIAL_STATUS_FER] && st.sta[`SERIAL_STATUS_FER_EN])); // R22

    // Reads answer two edges after the request
    next_st.rd_pend = sfr_rd;
    next_st.rd_addr = sfr_addr;
    next_st.rd_ok = cpu_pop;
    if (st.rd_pend) begin
      case (st.rd_addr)
        `HSU_ADDR_FLAGS: next_st.rdata = {5'h00, st.flags};
        `HSU_ADDR_IRQEN: next_st.rdata = st.irq_en;
        `HSU_ADDR_DATA: next_st.rdata = st.rd_ok ? ram_rdata : 8'h00; // R04
        `HSU_ADDR_DEPTH: next_st.rdata = st.depth;
        `HSU_ADDR_STA: next_st.rdata = {3'h0, st.sta};
        `HSU_ADDR_CTR: next_st.rdata = st.ctr;
        `HSU_ADDR_PRE: next_st.rdata = st.pre;
        `HSU_ADDR_CNT: next_st.rdata = st.cnt;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.ctr <= `SERIAL_CONTROL_RESET;
      st.tx_line <= 1'b1;
      st.rx_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata = st.rdata;
  assign cpu_irq = st.irq;
  assign serial_tx = st.tx_line;
  assign wake_request = st.wake;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_irq_group_gate: assert property (!peripheral_group_irq_enable |=> !cpu_irq) // R02
    else $error("interrupt raised while group enable is low");
  a_irq_flag_gate: assert property (
    (st.flags & st.irq_en[2:0]) == 3'h0 && !(st.sta[1] && st.sta[3])
    && !(st.sta[0] && st.sta[2]) |=> !cpu_irq) // R01
    else $error("interrupt raised with no enabled flag");
  a_depth_limit: assert property (st.depth <= `HSU_RX_DEPTH_MAX) // R05
    else $error("receive depth above its maximum");
  a_rx_bound: assert property (st.rx_count <= baud_counter_t'(st.depth)) // R07
    else $error("receive FIFO holds more than its depth");
  a_overrun_set: assert property (rx_drop |=> st.flags[1] && st.sta[`SERIAL_STATUS_OVR]) // R25
    else $error("dropped byte did not set overrun");
  a_frame_error: assert property (
    st.rx_st == RX_STOP && rx_sample && !serial_rx && soft_run && st.ctr[`SERIAL_CONTROL_RXEN]
    |=> st.sta[`SERIAL_STATUS_FER]) // R23
    else $error("low stop bit did not flag framing error");
  a_wake_level: assert property (
    st.wake_cnt == `HSU_WAKE_COUNT |-> wake_request) // R19
    else $error("wake request missing at count five");
  a_start_low: assert property (
    st.tx_st == TX_START && tx_tick && soft_run |=> !serial_tx ##1 st.tx_st == TX_DATA) // R08
    else $error("start bit not driven low");
  a_push_count: assert property (
    cpu_push && !tx_fetch |=> st.tx_count == $past(st.tx_count) + 1'b1) // R03
    else $error("transmit push not counted");

  c_byte_received: cover property (byte_done);
  c_byte_sent: cover property (st.tx_st == TX_STOP ##1 st.tx_st == TX_IDLE);
  c_preamble_done: cover property (st.armed ##1 !st.armed);
  c_wake_raised: cover property (!wake_request ##1 wake_request);
endmodule : hsu_uart
`default_nettype wire

/* verification/hsu_host_model.sv */
`default_nettype none
module hsu_host_model #(
  parameter int BIT_CLKS = 8
) (
  // Clock
  input wire logic clock,
  // Serial link
  input wire logic serial_tx,
  output logic serial_rx
);
  timeunit 1ns;
  timeprecision 1ns;

  bit seen = 1'b0;
  int gap_q[$];
  logic [7:0] byte_q[$];

  // Frame decoder: records each byte and the clocks between start bits
  initial begin
    int k;
    logic [7:0] b;
    forever begin
      k = 0;
      do begin
        @(negedge clock);
        k++;
      end while (serial_tx !== 1'b0);
      if (seen) begin
        gap_q.push_back(k + BIT_CLKS / 2 + 9 * BIT_CLKS);
      end
      seen = 1'b1;
      repeat (BIT_CLKS / 2) @(negedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(negedge clock);
        b[i] = serial_tx;
      end
      repeat (BIT_CLKS) @(negedge clock);
      byte_q.push_back(b);
    end
  end

  initial begin
    serial_rx = 1'b1;
  end

  // Start bit, eight data bits LSB first, one stop bit, then idle high
  task automatic send(input logic [7:0] b, input bit stop_good);
    logic [9:0] fr;
    fr = {stop_good, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock);
      serial_rx = fr[i];
      repeat (BIT_CLKS - 1) @(negedge clock);
    end
    @(negedge clock);
    serial_rx = 1'b1;
    repeat (2 * BIT_CLKS) @(negedge clock);
  endtask : send
endmodule : hsu_host_model
`default_nettype wire

/* verification/tb_top.sv */
`include "hsu_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Prescaler 1 and counter 3 give (3 + 1) * 2 clocks per bit
  localparam int BIT = 8;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic grp_en = 1'b0;
  logic cpu_irq;
  logic serial_rx;
  logic serial_tx;
  logic wake_request;
  int err_count = 0;
  int n_compared = 0;
  int exp_q[$];
  int depth = 0;
  bit armed = 1'b0;
  int pm = 0;
  int g0;
  int k;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] ra[6] = '{`HSU_ADDR_DEPTH, `HSU_ADDR_CTR, `HSU_ADDR_STA, `HSU_ADDR_PRE,
    `HSU_ADDR_CNT, 8'h50};
  logic [7:0] rv[6] = '{8'h00, `SERIAL_CONTROL_RESET, 8'h00, 8'h00, 8'h00, 8'h00};

  always #20 clock = ~clock;

  hsu_uart #(.RAM_DEPTH(256), .RX_WATERMARK(1)) dut_u (
    .clock(clock), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .peripheral_group_irq_enable(grp_en),
    .cpu_irq(cpu_irq), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .wake_request(wake_request)
  );

  hsu_host_model #(.BIT_CLKS(BIT)) host_u (
    .clock(clock), .serial_tx(serial_tx), .serial_rx(serial_rx)
  );

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : reg_wr

  // Read answer settles after the second edge past the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    repeat (2) @(negedge clock);
    d = sfr_rdata;
  endtask : reg_rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    reg_rd(a, d);
    chk(name, d, exp);
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    repeat (3) @(negedge clock);
    chk("cpu_irq", {7'h00, cpu_irq}, {7'h00, exp});
  endtask : irq_chk

  // Reference receive path: preamble filter, then depth-limited queue
  task automatic model_rx(input int b);
    if (armed) begin
      if (b == 0) pm = (pm < 2) ? pm + 1 : 2;
      else if (b == 255 && pm == 2) armed = 1'b0;
      else pm = 0;
    end else if (exp_q.size() < depth) begin
      exp_q.push_back(b);
    end
  endtask : model_rx

  task automatic host_send(input logic [7:0] b, input bit good);
    host_u.send(b, good);
    if (good) model_rx(int'(b));
  endtask : host_send

  task automatic drain();
    logic [7:0] d;
    while (exp_q.size() > 0) begin
      reg_rd(`HSU_ADDR_DATA, d);
      chk("rx byte", d, 8'(exp_q.pop_front()));
    end
    rd_chk(`HSU_ADDR_DATA, 8'h00, "empty read");
  endtask : drain

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(33972));
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i], "reset value");
    rd_chk(`HSU_ADDR_FLAGS, 8'h01, "flags at reset");
    reg_wr(`HSU_ADDR_DEPTH, 8'hC8);
    rd_chk(`HSU_ADDR_DEPTH, `HSU_RX_DEPTH_MAX, "depth clamp");
    reg_wr(`HSU_ADDR_DEPTH, 8'h04);
    depth = 4;
    reg_wr(`HSU_ADDR_PRE, 8'h01);
    reg_wr(`HSU_ADDR_CNT, 8'h03);
    rd_chk(`HSU_ADDR_CNT, 8'h03, "counter");
    // Every stop-bit code, with a received byte crossing at the same time
    for (int f = 0; f < 4; f++) begin
      reg_wr(`HSU_ADDR_CTR, {2'b00, f[1:0], 4'h7});
      host_u.seen = 1'b0;
      host_u.gap_q.delete();
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      fork
        begin
          reg_wr(`HSU_ADDR_DATA, b0);
          reg_wr(`HSU_ADDR_DATA, b1);
        end
        host_send(8'($urandom), 1'b1);
      join
      k = 0;
      while (host_u.byte_q.size() < 2 && k < 3000) begin
        @(negedge clock);
        k++;
      end
      chk("tx byte 0", host_u.byte_q.pop_front(), b0);
      chk("tx byte 1", host_u.byte_q.pop_front(), b1);
      if (f == 0) g0 = host_u.gap_q[0];
      chk("first gap", 8'((g0 == 10 * BIT) || (g0 == 11 * BIT)), 8'h01);
      chk("stop span", 8'(host_u.gap_q.pop_front() - g0), 8'(f * BIT));
      repeat (6 * BIT) @(negedge clock);
    end
    host_send(8'($urandom), 1'b1);
    rd_chk(`HSU_ADDR_FLAGS, 8'h07, "flags full");
    rd_chk(`HSU_ADDR_STA, 8'h02, "status overrun");
    reg_wr(`HSU_ADDR_IRQEN, 8'h02);
    irq_chk(1'b0);
    @(negedge clock);
    grp_en = 1'b1;
    irq_chk(1'b1);
    reg_wr(`HSU_ADDR_IRQEN, 8'h00);
    irq_chk(1'b0);
    reg_wr(`HSU_ADDR_IRQEN, 8'h04);
    irq_chk(1'b1);
    reg_wr(`HSU_ADDR_IRQEN, 8'h00);
    drain();
    reg_wr(`HSU_ADDR_FLAGS, 8'h87);
    reg_wr(`HSU_ADDR_STA, 8'h02);
    rd_chk(`HSU_ADDR_FLAGS, 8'h00, "flags cleared");
    rd_chk(`HSU_ADDR_STA, 8'h00, "status cleared");
    host_send(8'($urandom), 1'b0);
    rd_chk(`HSU_ADDR_STA, 8'h01, "framing flag");
    drain();
    reg_wr(`HSU_ADDR_STA, 8'h01);
    reg_wr(`HSU_ADDR_CTR, 8'h47);
    armed = 1'b1;
    pm = 0;
    host_send(8'h00, 1'b1);
    host_send(8'h00, 1'b1);
    host_send(8'hFF, 1'b1);
    host_send(8'h5A, 1'b1);
    drain();
    host_send(8'h00, 1'b1);
    host_send(8'h00, 1'b1);
    host_send(8'hFF, 1'b1);
    host_send(8'h33, 1'b1);
    drain();
    reg_wr(`HSU_ADDR_CTR, 8'h87);
    repeat (3) @(negedge clock);
    chk("wake cleared", {7'h00, wake_request}, 8'h00);
    host_send(8'h0F, 1'b1);
    chk("wake at two", {7'h00, wake_request}, 8'h00);
    host_send(8'h11, 1'b1);
    chk("wake at five", {7'h00, wake_request}, 8'h01);
    drain();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
